// ==== include/ctep_pkg.sv ====
// package for the cascaded timer with event counter and 12-bit pwm modes
package ctep_pkg;
   // register byte addresses (word aligned, index times four)
   localparam logic [7:0] CTEP_IDX_PWM_LOW = 8'h28;
   localparam logic [7:0] CTEP_IDX_PWM_HIGH = 8'h29;
   localparam logic [7:0] CTEP_ADR_CONTROL = 8'h00;
   localparam logic [7:0] CTEP_ADR_MODE = 8'h04;
   localparam logic [7:0] CTEP_ADR_CMP_LOW = 8'h08;
   localparam logic [7:0] CTEP_ADR_CMP_HIGH = 8'h0c;
   localparam logic [7:0] CTEP_ADR_STATUS = 8'h10;
   localparam logic [7:0] CTEP_ADR_COUNT = 8'h14;
   localparam logic [7:0] CTEP_ADR_PWM_LOW = 8'ha0;
   localparam logic [7:0] CTEP_ADR_PWM_HIGH = 8'ha4;
   // pair_control_reg fields
   localparam int CTEP_CR_LOW_RUN = 0;
   localparam int CTEP_CR_HIGH_RUN = 1;
   localparam int CTEP_CR_CASCADE = 2;
   // high_mode_reg fields
   localparam int CTEP_MD_MODE_LSB = 0;
   localparam int CTEP_MD_EXT_SRC = 2;
   localparam int CTEP_MD_INIT_LEVEL = 3;
   localparam int CTEP_MD_SRC_LSB = 4;
   localparam int CTEP_MD_DBL_BUF = 7;
   // mode field codes
   localparam logic [1:0] CTEP_MODE_EVENT = 2'h1;
   localparam logic [1:0] CTEP_MODE_PWM = 2'h2;
   // reset values
   localparam logic [7:0] CTEP_RST_PWM = 8'hff;
   localparam logic [7:0] CTEP_RST_MODE = 8'h00;
   localparam logic [7:0] CTEP_RST_CMP = 8'hff;
   // pwm frame: 16 cycles of 256 counts
   localparam logic [3:0] CTEP_LAST_CYCLE = 4'hf;
endpackage

// ==== rtl/ctep_src_gen.sv ====
// source clock tick generator: prescaled internal clock or synchronised falling edges
`timescale 1ns/10ps
module ctep_src_gen
   import ctep_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // selection
   input wire logic ext_sel,
   input wire logic [2:0] src_sel,
   // external event pin
   input wire logic event_input_pin,
   // tick out
   output logic tick
);
   logic [1:0] pin_sync;
   logic pin_prev;
   logic [10:0] presc;
   logic presc_tick;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_sync <= 2'h3;
         pin_prev <= 1'b1;
      end else begin
         pin_sync <= {pin_sync[0], event_input_pin};
         pin_prev <= pin_sync[1];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         presc <= 11'h000;
      end else begin
         presc <= presc + 11'h001;
      end
   end

   // divider per select code: 2^11,2^10,2^8,2^6,2^4,2^2,2^1,2^0
   always_comb begin
      case (src_sel)
         3'h0: presc_tick = (presc == 11'h7ff);
         3'h1: presc_tick = (presc[9:0] == 10'h3ff);
         3'h2: presc_tick = (presc[7:0] == 8'hff);
         3'h3: presc_tick = (presc[5:0] == 6'h3f);
         3'h4: presc_tick = (presc[3:0] == 4'hf);
         3'h5: presc_tick = (presc[1:0] == 2'h3);
         3'h6: presc_tick = presc[0];
         default: presc_tick = 1'b1;
      endcase
   end

   // the source must hold each level two cycles, else edges are lost here
   assign tick = ext_sel ? (pin_prev & ~pin_sync[1]) : presc_tick;
endmodule

// ==== rtl/ctep_timer.sv ====
// cascaded timer pair: 16-bit event counter and 12-bit pwm, wishbone slave
`timescale 1ns/10ps
// Contract
// - event mode counts falling edges while running
// - compare match raises high irq, clears counter
// - stopping event counter clears count to zero
// - cascade bit joins timers, high settings rule
// - mode 10 is pwm; source bit selects
// - mode register writes ignored while running
// - pwm high upper nibble stored, no effect
// - duty nibbles form 8-bit first-toggle time
// - extra pulse bits select cycles of sixteen
// - stopped output drives initial level
// - low count equals duty toggles output; a zero duty without an extra pulse never toggles here
// - extra pulse cycles toggle at duty plus one
// - zero extra bits means no extra pulses
// - overflow at 256 clears, restores, low irq
// - pwm high irq every 16th overflow
// - double buffering only when enable bit set
// - event compare buffered until next match
// - pwm setting buffered to 16-cycle boundary
// - stopping pwm clears counter, restores level
module ctep_timer
   import ctep_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic event_input_pin,
   output logic pulse_output_pin,
   // interrupt requests, one-cycle pulses
   output logic low_timer_irq,
   output logic high_timer_irq
);
   typedef enum logic [2:0] {
      CTEP_ST_IDLE = 3'b001,
      CTEP_ST_EVENT = 3'b010,
      CTEP_ST_PWM = 3'b100
   } ctep_state_e;

   ctep_state_e state;
   ctep_state_e next_state;
   logic [7:0] pair_control_reg;
   logic [7:0] high_mode_reg;
   logic [7:0] compare_low_reg;
   logic [15:0] cmp_buf;
   logic [15:0] combined_compare_value;
   logic cmp_pending;
   logic [7:0] pwm_setting_low;
   logic [7:0] pwm_setting_high;
   logic [11:0] pwm_active;
   logic pwm_pending;
   logic [15:0] count;
   logic [3:0] cycle_idx;
   logic tick;
   logic running;
   logic wr;
   logic rd_hit;
   logic [7:0] duty_value;
   logic [3:0] extra_bits;
   logic extra_now;
   logic duty_hit;
   logic ovf;
   logic match;
   logic dbl;
   logic init_level;

   function automatic logic extra_cycle(input logic [3:0] bits, input logic [3:0] idx);
      // idx 0..15 is cycle 1..16
      logic [4:0] c;
      c = {1'b0, idx} + 5'h01;
      extra_cycle = (bits[0] && c == 5'd9) || (bits[1] && (c == 5'd5 || c == 5'd13))
         || (bits[2] && c[1:0] == 2'h3) || (bits[3] && !c[0]);
   endfunction

   ctep_src_gen u_src (
      .clk(clk),
      .arst_n(arst_n),
      .ext_sel(high_mode_reg[CTEP_MD_EXT_SRC]),
      .src_sel(high_mode_reg[CTEP_MD_SRC_LSB +: 3]),
      .event_input_pin(event_input_pin),
      .tick(tick)
   );

   // classic wishbone: ack one cycle after strobe; a write lands on the edge where ack is seen
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   // the low run bit only locks the mode register; only the high run bit and cascade start it
   assign running = pair_control_reg[CTEP_CR_HIGH_RUN] && pair_control_reg[CTEP_CR_CASCADE];
   assign dbl = high_mode_reg[CTEP_MD_DBL_BUF];
   assign init_level = high_mode_reg[CTEP_MD_INIT_LEVEL];
   assign duty_value = pwm_active[11:4];
   assign extra_bits = pwm_active[3:0];
   assign extra_now = extra_cycle(extra_bits, cycle_idx);
   // toggle on the tick that brings the count to the duty, in step with the overflow restore;
   // limitation: a zero duty without an extra pulse never toggles
   assign duty_hit = tick
      && count[7:0] + 8'h01 == (extra_now ? duty_value + 8'h01 : duty_value);
   assign ovf = tick && count[7:0] == 8'hff;
   assign match = state == CTEP_ST_EVENT && count == combined_compare_value;

   always_comb begin
      next_state = state;
      case (state)
         CTEP_ST_IDLE: begin
            if (running && high_mode_reg[CTEP_MD_MODE_LSB +: 2] == CTEP_MODE_PWM) begin
               next_state = CTEP_ST_PWM;
            end else if (running && high_mode_reg[CTEP_MD_MODE_LSB +: 2] == CTEP_MODE_EVENT) begin
               next_state = CTEP_ST_EVENT;
            end
         end
         CTEP_ST_EVENT, CTEP_ST_PWM: begin
            if (!running) begin
               next_state = CTEP_ST_IDLE;
            end
         end
         default: next_state = CTEP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= CTEP_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // bus registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pair_control_reg <= 8'h00;
         high_mode_reg <= CTEP_RST_MODE;
         compare_low_reg <= CTEP_RST_CMP;
         pwm_setting_low <= CTEP_RST_PWM;
      end else if (wr) begin
         case (wb_adr_i)
            CTEP_ADR_CONTROL: pair_control_reg <= {5'h00, wb_dat_i[2:0]};
            CTEP_ADR_MODE: begin
               if (!pair_control_reg[CTEP_CR_HIGH_RUN] && !pair_control_reg[CTEP_CR_LOW_RUN]) begin
                  high_mode_reg <= wb_dat_i[7:0];
               end
            end
            CTEP_ADR_CMP_LOW: compare_low_reg <= wb_dat_i[7:0];
            CTEP_ADR_PWM_LOW: pwm_setting_low <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // compare value: high write commits, buffered while counting events with double buffering on
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_buf <= {CTEP_RST_CMP, CTEP_RST_CMP};
         combined_compare_value <= {CTEP_RST_CMP, CTEP_RST_CMP};
         cmp_pending <= 1'b0;
      end else if (wr && wb_adr_i == CTEP_ADR_CMP_HIGH) begin
         cmp_buf <= {wb_dat_i[7:0], compare_low_reg};
         if (state == CTEP_ST_EVENT && dbl) begin
            cmp_pending <= 1'b1;
         end else begin
            combined_compare_value <= {wb_dat_i[7:0], compare_low_reg};
         end
      end else if (match && cmp_pending) begin
         combined_compare_value <= cmp_buf;
         cmp_pending <= 1'b0;
      end
   end

   // pwm setting: high write commits both halves
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_setting_high <= CTEP_RST_PWM;
         pwm_active <= {CTEP_RST_PWM[3:0], CTEP_RST_PWM};
         pwm_pending <= 1'b0;
      end else if (wr && wb_adr_i == CTEP_ADR_PWM_HIGH) begin
         pwm_setting_high <= wb_dat_i[7:0];
         if (state == CTEP_ST_PWM && dbl) begin
            pwm_pending <= 1'b1;
         end else begin
            pwm_active <= {wb_dat_i[3:0], pwm_setting_low};
         end
      end else if (ovf && state == CTEP_ST_PWM && cycle_idx == CTEP_LAST_CYCLE && pwm_pending) begin
         pwm_active <= {pwm_setting_high[3:0], pwm_setting_low};
         pwm_pending <= 1'b0;
      end
   end

   // counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 16'h0000;
         cycle_idx <= 4'h0;
      end else if (state != next_state || state == CTEP_ST_IDLE) begin
         count <= 16'h0000;
         cycle_idx <= 4'h0;
      end else if (state == CTEP_ST_EVENT) begin
         if (match) begin
            count <= 16'h0000;
         end else if (tick) begin
            count <= count + 16'h0001;
         end
      end else if (tick) begin
         if (ovf) begin
            count <= 16'h0000;
            cycle_idx <= cycle_idx + 4'h1;
         end else begin
            count <= count + 16'h0001;
         end
      end
   end

   // pwm output pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_output_pin <= 1'b0;
      end else if (state != CTEP_ST_PWM || next_state != CTEP_ST_PWM) begin
         pulse_output_pin <= init_level;
      end else if (ovf) begin
         pulse_output_pin <= init_level;
      end else if (duty_hit) begin
         pulse_output_pin <= ~init_level;
      end
   end

   // interrupt pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_timer_irq <= 1'b0;
         high_timer_irq <= 1'b0;
      end else begin
         low_timer_irq <= state == CTEP_ST_PWM && running && ovf;
         high_timer_irq <= (match && running)
            || (state == CTEP_ST_PWM && running && ovf && cycle_idx == CTEP_LAST_CYCLE);
      end
   end

   // read mux and ack
   assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (rd_hit) begin
            case (wb_adr_i)
               CTEP_ADR_CONTROL: wb_dat_o <= {24'h000000, pair_control_reg};
               CTEP_ADR_MODE: wb_dat_o <= {24'h000000, high_mode_reg};
               CTEP_ADR_CMP_LOW: wb_dat_o <= {24'h000000, cmp_buf[7:0]};
               CTEP_ADR_CMP_HIGH: wb_dat_o <= {24'h000000, cmp_buf[15:8]};
               CTEP_ADR_STATUS: wb_dat_o <= {24'h000000, pulse_output_pin, state, cycle_idx};
               CTEP_ADR_COUNT: wb_dat_o <= {16'h0000, count};
               CTEP_ADR_PWM_LOW: wb_dat_o <= {24'h000000, pwm_setting_low};
               CTEP_ADR_PWM_HIGH: wb_dat_o <= {24'h000000, pwm_setting_high};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   AST_EVENT_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
      match |=> count == 16'h0000 && high_timer_irq) else $error("match did not clear");
   AST_STOP_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
      (state != CTEP_ST_IDLE && !running) |=> count == 16'h0000) else $error("stop kept count");
   AST_IDLE_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
      ##1 (state == CTEP_ST_IDLE && $past(state) == CTEP_ST_IDLE) |-> pulse_output_pin == $past(init_level))
      else $error("idle level wrong");
   AST_OVF_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
      (state == CTEP_ST_PWM && running && ovf) |=> low_timer_irq && pulse_output_pin == init_level)
      else $error("overflow wrong");
   AST_HIGH_IRQ_PWM: assert property (@(posedge clk) disable iff (!arst_n)
      (state == CTEP_ST_PWM && low_timer_irq && !high_timer_irq) |-> $past(cycle_idx) != CTEP_LAST_CYCLE)
      else $error("high irq missed");
   AST_MODE_LOCK: assert property (@(posedge clk) disable iff (!arst_n)
      pair_control_reg[CTEP_CR_HIGH_RUN] |=> $stable(high_mode_reg)) else $error("mode changed running");
   AST_DUTY_TOGGLE: assert property (@(posedge clk) disable iff (!arst_n)
      (state == CTEP_ST_PWM && running && !ovf && duty_hit && tick) |=> pulse_output_pin != init_level)
      else $error("duty toggle missed");
   AST_EVENT_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
      (state == CTEP_ST_EVENT && running && tick && !match) |=> count == $past(count) + 16'h0001)
      else $error("event not counted");
endmodule

// ==== tb/ctep_partner.sv ====
// partner model: external falling-edge source and pwm load monitor
`timescale 1ns/10ps
module ctep_partner
   import ctep_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // request from the bench
   input wire logic burst,
   // device pins and irqs
   output logic event_input_pin,
   input wire logic pulse_output_pin,
   input wire logic low_timer_irq,
   input wire logic high_timer_irq,
   // results
   output logic [15:0] edges,
   output logic [15:0] hi_clocks,
   output logic [15:0] lo_irqs
);
   logic [1:0] hold;
   logic [15:0] hi_acc;
   logic [15:0] lo_acc;
   // each level is held four clocks, above the two-cycle minimum; idle is high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold <= 2'h0;
         event_input_pin <= 1'b1;
         edges <= 16'h0;
      end else begin
         hold <= hold + 2'h1;
         if (hold == 2'h3 && !event_input_pin) begin
            event_input_pin <= 1'b1;
         end else if (hold == 2'h3 && burst) begin
            event_input_pin <= 1'b0;
            edges <= edges + 16'h1;
         end
      end
   end
   // the window between two frame irqs is one whole frame, so phase does not matter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hi_acc <= 16'h0;
         lo_acc <= 16'h0;
         hi_clocks <= 16'h0;
         lo_irqs <= 16'h0;
      end else if (high_timer_irq) begin
         hi_clocks <= hi_acc;
         lo_irqs <= lo_acc;
         hi_acc <= {15'h0, pulse_output_pin};
         lo_acc <= {15'h0, low_timer_irq};
      end else begin
         hi_acc <= hi_acc + {15'h0, pulse_output_pin};
         lo_acc <= lo_acc + {15'h0, low_timer_irq};
      end
   end
endmodule

// ==== tb/ctep_timer_test.sv ====
// self-checking bench for the cascaded timer: registers, event counting, pwm frames
`timescale 1ns/10ps
module ctep_timer_test
   import ctep_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic burst = 1'b0;
   logic ev_pin;
   logic pin;
   logic lo_irq;
   logic hi_irq;
   logic [15:0] edges;
   logic [15:0] hi_clocks;
   logic [15:0] lo_irqs;
   logic [31:0] r;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int hi_irqs = 0;
   int n;
   // rows: pwm low, pwm high, expected high clocks per 16-cycle frame
   logic [7:0] row_lo [5] = '{8'h00, 8'h01, 8'h02, 8'he4, 8'h18};
   logic [7:0] row_hi [5] = '{8'h01, 8'h01, 8'ha8, 8'h0f, 8'h00};
   logic [15:0] row_hc [5] = '{16'd3840, 16'd3839, 16'd2046, 16'd28, 16'd4072};

   always #10 clk = ~clk;

   ctep_timer dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .event_input_pin(ev_pin), .pulse_output_pin(pin), .low_timer_irq(lo_irq), .high_timer_irq(hi_irq));
   ctep_partner load (.clk(clk), .arst_n(arst_n), .burst(burst), .event_input_pin(ev_pin),
      .pulse_output_pin(pin), .low_timer_irq(lo_irq), .high_timer_irq(hi_irq), .edges(edges),
      .hi_clocks(hi_clocks), .lo_irqs(lo_irqs));

   always @(posedge clk) begin
      if (hi_irq === 1'b1) hi_irqs++;
      cycles++;
      if (cycles == 90000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask

   // classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      r = rdat;
      if (k >= 50) miscompares++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 8'h00);
      chk(nm, exp, r);
   endtask

   task automatic wait_hi();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hi_irq !== 1'b1 && n < 6000);
      if (n >= 6000) miscompares++;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      rdc("pwm low reset", CTEP_ADR_PWM_LOW, 32'hff);
      rdc("pwm high reset", CTEP_ADR_PWM_HIGH, 32'hff);
      rdc("mode reset", CTEP_ADR_MODE, 32'h00);
      rdc("cmp low reset", CTEP_ADR_CMP_LOW, 32'hff);
      wb(1'b1, 8'h18, 8'h55);
      rdc("unmapped", 8'h18, 32'h0);
      $display("test reset done");
      // event mode from the pin, compare value 3
      wb(1'b1, CTEP_ADR_MODE, 8'h05);
      wb(1'b1, CTEP_ADR_CMP_LOW, 8'h03);
      wb(1'b1, CTEP_ADR_CMP_HIGH, 8'h00);
      wb(1'b1, CTEP_ADR_CONTROL, 8'h06);
      wb(1'b1, CTEP_ADR_MODE, 8'h02);
      rdc("mode locked", CTEP_ADR_MODE, 32'h05);
      hi_irqs = 0;
      burst <= 1'b1;
      for (n = 0; n < 400 && edges !== 16'd3; n++) @(posedge clk);
      burst <= 1'b0;
      repeat (20) @(posedge clk);
      chk("match irqs", 32'd1, hi_irqs);
      rdc("count after match", CTEP_ADR_COUNT, 32'h0);
      burst <= 1'b1;
      for (n = 0; n < 400 && edges !== 16'd5; n++) @(posedge clk);
      burst <= 1'b0;
      repeat (20) @(posedge clk);
      rdc("count two edges", CTEP_ADR_COUNT, 32'h2);
      wb(1'b1, CTEP_ADR_CONTROL, 8'h04);
      rdc("count stopped", CTEP_ADR_COUNT, 32'h0);
      $display("test event done");
      // pwm, source divide by one
      wb(1'b1, CTEP_ADR_MODE, 8'h7a);
      repeat (3) @(posedge clk);
      chk("idle level high", 32'h1, {31'h0, pin});
      wb(1'b1, CTEP_ADR_MODE, 8'h72);
      repeat (3) @(posedge clk);
      chk("idle level low", 32'h0, {31'h0, pin});
      wb(1'b1, CTEP_ADR_CONTROL, 8'h06);
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, CTEP_ADR_PWM_LOW, row_lo[i]);
         wb(1'b1, CTEP_ADR_PWM_HIGH, row_hi[i]);
         rdc("pwm high readback", CTEP_ADR_PWM_HIGH, {24'h0, row_hi[i]});
         wait_hi();
         wait_hi();
         @(posedge clk);
         chk("frame high clocks", {16'h0, row_hc[i]}, {16'h0, hi_clocks});
         chk("frame overflows", 32'd16, {16'h0, lo_irqs});
      end
      wb(1'b1, CTEP_ADR_MODE, 8'h7a);
      rdc("pwm mode locked", CTEP_ADR_MODE, 32'h72);
      wb(1'b1, CTEP_ADR_CONTROL, 8'h04);
      repeat (3) @(posedge clk);
      chk("stopped level", 32'h0, {31'h0, pin});
      rdc("pwm count stopped", CTEP_ADR_COUNT, 32'h0);
      $display("test pwm done");
      // double buffer: a setting written mid-frame waits for the frame boundary
      wb(1'b1, CTEP_ADR_MODE, 8'hf2);
      wb(1'b1, CTEP_ADR_CONTROL, 8'h06);
      wait_hi();
      wb(1'b1, CTEP_ADR_PWM_LOW, row_lo[0]);
      wb(1'b1, CTEP_ADR_PWM_HIGH, row_hi[0]);
      rdc("buffered readback", CTEP_ADR_PWM_HIGH, {24'h0, row_hi[0]});
      wait_hi();
      @(posedge clk);
      chk("old frame kept", {16'h0, row_hc[4]}, {16'h0, hi_clocks});
      wait_hi();
      @(posedge clk);
      chk("new frame loaded", {16'h0, row_hc[0]}, {16'h0, hi_clocks});
      $display("test double buffer done");
      // reset in mid-run: outputs and registers return to their reset values
      repeat (300) @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pin in reset", 32'h0, {31'h0, pin});
      arst_n <= 1'b1;
      rdc("control after reset", CTEP_ADR_CONTROL, 32'h0);
      rdc("pwm high after reset", CTEP_ADR_PWM_HIGH, 32'hff);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
